//--- rtl/cpiv_defines.svh
// Shared constants of the coprocessor instruction-issue port.
// Assumes inclusion by bare name from the package; the modules use its macros without including it.
`ifndef CPIV_DEFINES_SVH
`define CPIV_DEFINES_SVH

// Width of the broadcast coprocessor instruction bus
`define CPIV_INSTR_W     26
// Field of the instruction that names the owning coprocessor
`define CPIV_CPNUM_LSB   8
`define CPIV_CPNUM_W     4
// Largest coprocessor number the field can carry
`define CPIV_CPNUM_MAX   15
// Value forced onto the bus while the issue hint is low
`define CPIV_BUS_IDLE    26'h0000000

`endif

//--- rtl/cpiv_pkg.sv
// Types shared by both ends of the coprocessor instruction-issue port.
// Assumes cpiv_defines.svh is on the include path.
`include "cpiv_defines.svh"

package cpiv_pkg;

  typedef logic [`CPIV_INSTR_W-1:0] cpiv_instr_t;
  typedef logic [`CPIV_CPNUM_W-1:0] cpiv_cpnum_t;

  // One pipeline slot of the core
  typedef struct packed {
    logic        valid;
    logic        cop;
    logic        abort;
    cpiv_instr_t instr;
  } cpiv_slot_t;

  typedef struct packed {
    cpiv_slot_t  issue;
    cpiv_slot_t  decode;
    logic        hint;
    cpiv_instr_t bus;
    logic        confirm;
    logic        dstall;
    logic        estall;
    logic        flush;
    logic        cancel;
    logic        taken;
  } cpiv_core_state_t;

  typedef enum logic [1:0] {
    CPIV_EX_IDLE = 2'b00,
    CPIV_EX_RUN  = 2'b01
  } cpiv_ex_t;

  typedef struct packed {
    logic        fvalid;
    cpiv_instr_t finstr;
    cpiv_ex_t    ex;
    logic        acc_valid;
    cpiv_instr_t acc_instr;
    logic        acc_cancel;
    logic        busy;
    logic        busy_oe;
  } cpiv_cop_state_t;

  // Coprocessor number carried by an instruction
  function automatic cpiv_cpnum_t cpiv_cpnum(input cpiv_instr_t i);
    return i[`CPIV_CPNUM_LSB +: `CPIV_CPNUM_W];
  endfunction

endpackage

//--- rtl/cpiv_if.sv
// Instruction-issue port between the core and its coprocessors.
// Assumes one clock shared by both ends; the busy line is resolved here.
`timescale 1ns/1ns

interface cpiv_if;
  import cpiv_pkg::*;

  cpiv_instr_t cop_instr_bus;
  logic        issue_hint_valid;
  logic        decode_confirm_valid;
  logic        decode_stage_stall;
  logic        execute_stage_stall;
  logic        pipeline_flush;
  logic        instr_cancel;
  logic        coproc_busy_drv;
  logic        coproc_busy_oe;
  logic        coproc_busy_execute;

  // Only the owning coprocessor enables its busy driver
  assign coproc_busy_execute = coproc_busy_oe & coproc_busy_drv;

  modport core_mp (
    output cop_instr_bus,
    output issue_hint_valid,
    output decode_confirm_valid,
    output decode_stage_stall,
    output execute_stage_stall,
    output pipeline_flush,
    output instr_cancel,
    input  coproc_busy_execute
  );

  modport cop_mp (
    input  cop_instr_bus,
    input  issue_hint_valid,
    input  decode_confirm_valid,
    input  decode_stage_stall,
    input  execute_stage_stall,
    input  pipeline_flush,
    input  instr_cancel,
    input  coproc_busy_execute,
    output coproc_busy_drv,
    output coproc_busy_oe
  );
endinterface

//--- rtl/cpiv_core_end.sv
// Core end of the coprocessor instruction-issue port: Issue and Decode
// slots that broadcast the hint, the bus and the decode confirmation.
// Assumes the core pipeline supplies fetched words and hold requests
// on clk, and that coprocessors drive busy synchronously to clk.
//
// What this block and cpiv_cop_end do
// [RL1] Issue stage drives only bus and hint
// [RL2] Hint high does not prove valid instruction
// [RL3] Hint low means bus holds nothing valid
// [RL4] Bus forced to zero while hint low
// [RL5] Coprocessor never relies on zeroed bus
// [RL6] Coprocessor may skip decode when hint low
// [RL7] Hint may rise for later-invalid instructions
// [RL8] Hint driven in Issue stage
// [RL9] Confirmation high in Decode for valid instruction
// [RL10] Confirmed instruction may still be cancelled
// [RL11] Coprocessor samples hint only when holds low
// [RL12] Hint and bus may change under interlock
// [RL13] Confirmation ignored while stalls are high
// [RL14] Confirmation driven in Decode stage
// [RL15] Instructions broadcast on dedicated 26-bit bus
// [RL16] Only owning coprocessor drives control back
// [RL17] Hint and confirmation low after reset
`timescale 1ns/1ns

module cpiv_core_end
  import cpiv_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               fetch_valid,
  input  wire cpiv_pkg::cpiv_instr_t fetch_instr,
  input  wire logic               fetch_cop,
  input  wire logic               fetch_abort,
  input  wire logic               branch_kill,
  input  wire logic               hold_decode,
  input  wire logic               hold_execute,
  input  wire logic               flush_req,
  input  wire logic               cancel_req,
  output logic                    fetch_taken,
  output logic                    interlocked,
  cpiv_if.core_mp                 port
);
  import cpiv_pkg::*;

  cpiv_core_state_t state;
  cpiv_core_state_t next_state;

  logic hold;
  logic advance;
  logic take;

  // Issue stage moves only once every hold is low; the coprocessor
  // sees the same stall levels, so both sides agree on the last
  // interlocked cycle.
  always_comb begin
    hold    = state.dstall | state.estall | port.coproc_busy_execute;
    advance = ~hold;
    take    = fetch_valid & (advance | ~state.issue.valid);
  end

  always_comb begin
    next_state = state;
    next_state.dstall = hold_decode;
    next_state.estall = hold_execute;
    next_state.flush  = flush_req;
    next_state.cancel = cancel_req;
    next_state.taken  = 1'b0;

    if (flush_req) begin
      // Flush empties both slots; nothing stays hinted or confirmed
      next_state.issue  = '0;
      next_state.decode = '0;
    end else begin
      if (advance) begin
        next_state.decode = state.issue;
        // A branch resolved wrong drops the word on its way to Decode
        if (branch_kill) begin
          next_state.decode.valid = 1'b0; // [RL7]
        end
      end
      if (advance | ~state.issue.valid) begin
        // Empty or moving slot refills, even under interlock
        next_state.issue.valid = fetch_valid; // [RL12]
        next_state.issue.cop   = fetch_cop;
        next_state.issue.abort = fetch_abort;
        next_state.issue.instr = fetch_instr;
        next_state.taken       = take;
      end else if (branch_kill) begin
        // Held word turns invalid after a mispredict
        next_state.issue.valid = 1'b0; // [RL12]
      end
    end

    // Hint follows the Issue slot; aborted words still raise it
    next_state.hint = next_state.issue.valid &
                      next_state.issue.cop; // [RL8] [RL7] [RL2]
    if (next_state.hint) begin
      next_state.bus = next_state.issue.instr; // [RL15]
    end else begin
      next_state.bus = `CPIV_BUS_IDLE; // [RL3] [RL4]
    end

    // Confirmation follows the Decode slot, refused for aborts
    next_state.confirm = next_state.decode.valid &
                         next_state.decode.cop &
                         ~next_state.decode.abort; // [RL9] [RL14]

    if (sys_rst) begin
      next_state = '0; // [RL17]
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  // Only bus and hint come from the Issue slot; stalls, flush and
  // cancel are registered requests of later stages.
  always_comb begin
    port.cop_instr_bus        = state.bus;     // [RL1]
    port.issue_hint_valid     = state.hint;    // [RL1]
    port.decode_confirm_valid = state.confirm; // [RL10]
    port.decode_stage_stall   = state.dstall;
    port.execute_stage_stall  = state.estall;
    port.pipeline_flush       = state.flush;
    port.instr_cancel         = state.cancel;
    fetch_taken               = state.taken;
    interlocked               = state.dstall | state.estall;
  end

endmodule

//--- rtl/cpiv_cop_end.sv
// Coprocessor end of the instruction-issue port: samples hinted words
// it owns, accepts them on confirmation and drives its busy line.
// Assumes the core end drives the port on the same clk.
`timescale 1ns/1ns

module cpiv_cop_end
  import cpiv_pkg::*;
#(
  parameter int CP_ID = 1
)
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               exec_busy,
  input  wire logic               exec_done,
  output logic                    acc_valid,
  output cpiv_pkg::cpiv_instr_t   acc_instr,
  output logic                    acc_cancel,
  cpiv_if.cop_mp                  port
);
  import cpiv_pkg::*;

  if (CP_ID < 0 || CP_ID > `CPIV_CPNUM_MAX) begin : g_bad_id
    $error("CP_ID does not fit the coprocessor number field");
  end

  cpiv_cop_state_t state;
  cpiv_cop_state_t next_state;

  logic hold;
  logic mine;

  always_comb begin
    hold = port.decode_stage_stall | port.execute_stage_stall |
           port.coproc_busy_execute;
    // Bus is decoded only while hinted; zeros on it mean nothing
    mine = port.issue_hint_valid &
           (cpiv_cpnum(port.cop_instr_bus) ==
            CP_ID[`CPIV_CPNUM_W-1:0]); // [RL6] [RL5]
  end

  always_comb begin
    next_state = state;
    next_state.acc_valid  = 1'b0;
    next_state.acc_cancel = 1'b0;

    case (state.ex)
      CPIV_EX_IDLE: begin
      end
      CPIV_EX_RUN: begin
        if (port.instr_cancel) begin
          // Confirmed work can still be cancelled
          next_state.ex         = CPIV_EX_IDLE; // [RL10]
          next_state.acc_cancel = 1'b1;
        end else if (exec_done) begin
          next_state.ex = CPIV_EX_IDLE;
        end
      end
      default: begin
        next_state.ex = CPIV_EX_IDLE;
      end
    endcase

    if (port.pipeline_flush) begin
      next_state.fvalid = 1'b0;
      next_state.ex     = CPIV_EX_IDLE; // [RL10]
    end else if (~hold) begin
      // Last interlocked cycle: trust confirmation and hint now
      if (state.fvalid & port.decode_confirm_valid) begin
        next_state.acc_valid = 1'b1; // [RL13] [RL2]
        next_state.acc_instr = state.finstr;
        next_state.ex        = CPIV_EX_RUN;
      end
      next_state.fvalid = mine; // [RL11]
      next_state.finstr = port.cop_instr_bus;
    end

    // Busy is driven only for work this coprocessor owns
    next_state.busy_oe = (next_state.ex == CPIV_EX_RUN); // [RL16]
    next_state.busy    = next_state.busy_oe & exec_busy;

    if (sys_rst) begin
      next_state = '0; // [RL17]
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  always_comb begin
    port.coproc_busy_drv = state.busy;
    port.coproc_busy_oe  = state.busy_oe;
    acc_valid            = state.acc_valid;
    acc_instr            = state.acc_instr;
    acc_cancel           = state.acc_cancel;
  end

endmodule

//--- verif/cpiv_properties.sv
// Port checker for the coprocessor instruction-issue interface.
// Assumes plain inputs wired from cpiv_if beside the two ends.
`timescale 1ns/1ns

module cpiv_properties (
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire cpiv_pkg::cpiv_instr_t cop_instr_bus,
  input wire logic                  issue_hint_valid,
  input wire logic                  decode_confirm_valid,
  input wire logic                  decode_stage_stall,
  input wire logic                  execute_stage_stall,
  input wire logic                  pipeline_flush,
  input wire logic                  coproc_busy_oe,
  input wire logic                  coproc_busy_execute
);
  import cpiv_pkg::*;
  logic hold;
  assign hold = decode_stage_stall | execute_stage_stall | coproc_busy_execute;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_bus_zero;
    !issue_hint_valid |-> cop_instr_bus == 26'h0000000;
  endproperty
  a_bus_zero: assert property (p_bus_zero)
    else $error("bus not zero while hint low");
  property p_idle;
    !issue_hint_valid && !hold |=> !decode_confirm_valid;
  endproperty
  a_idle: assert property (p_idle)
    else $error("confirm without hinted word");
  property p_rise;
    $rose(decode_confirm_valid) |-> $past(issue_hint_valid);
  endproperty
  a_rise: assert property (p_rise)
    else $error("confirm rose without prior hint");
  property p_rst;
    $fell(sys_rst) |-> !issue_hint_valid && !decode_confirm_valid
      && !coproc_busy_oe;
  endproperty
  a_rst: assert property (p_rst)
    else $error("port active after reset");
  property p_flush;
    pipeline_flush |-> !issue_hint_valid && !decode_confirm_valid;
  endproperty
  a_flush: assert property (p_flush)
    else $error("slots not emptied by flush");
  property p_flush_drop;
    pipeline_flush |=> !coproc_busy_oe;
  endproperty
  a_flush_drop: assert property (p_flush_drop)
    else $error("execution kept after flush");
  property p_accept;
    $rose(coproc_busy_oe) |-> $past(decode_confirm_valid && !hold);
  endproperty
  a_accept: assert property (p_accept)
    else $error("accepted without confirm or under hold");
  property p_owner;
    coproc_busy_execute |-> coproc_busy_oe;
  endproperty
  a_owner: assert property (p_owner)
    else $error("busy driven by non-owner");
  property p_width;
    issue_hint_valid |-> $bits(cop_instr_bus) == 26;
  endproperty
  a_width: assert property (p_width)
    else $error("instruction bus width wrong");
  property p_held;
    hold |=> $stable(decode_confirm_valid) || pipeline_flush;
  endproperty
  a_held: assert property (p_held)
    else $error("confirm moved while held");
endmodule

//--- verif/tb_cp_instruction_validity_issue.sv
// Self-checking bench: core end and coprocessor end joined by cpiv_if.
// Assumes the package, header and design files are compiled first.
`timescale 1ns/1ns

module tb_cp_instruction_validity_issue;
  import cpiv_pkg::*;
  typedef struct packed {
    cpiv_instr_t instr;
    logic        cop;
    logic        abort;
    logic        hint;
    logic        conf;
    logic        acc;
  } cpiv_row_t;
  logic        clk = 0, sys_rst = 1, fetch_valid = 0, fetch_cop = 0;
  logic        fetch_abort = 0, branch_kill = 0, hold_decode = 0;
  logic        hold_execute = 0, flush_req = 0, cancel_req = 0;
  logic        exec_busy = 0, exec_done = 0;
  logic        fetch_taken, interlocked, acc_valid, acc_cancel;
  cpiv_instr_t fetch_instr = '0, acc_instr;
  int          err_count = 0, n_checks = 0;
  cpiv_row_t   rows[5] = '{'{26'h0000123, 1, 0, 1, 1, 1},
    '{26'h0000155, 1, 1, 1, 0, 0}, '{26'h0000234, 1, 0, 1, 1, 0},
    '{26'h3ffffff, 1, 0, 1, 1, 0}, '{26'h0000177, 0, 0, 0, 0, 0}};

  cpiv_if lnk ();
  cpiv_core_end i_cpiv_core_end (.clk(clk), .sys_rst(sys_rst),
    .fetch_valid(fetch_valid), .fetch_instr(fetch_instr),
    .fetch_cop(fetch_cop), .fetch_abort(fetch_abort),
    .branch_kill(branch_kill), .hold_decode(hold_decode),
    .hold_execute(hold_execute), .flush_req(flush_req),
    .cancel_req(cancel_req), .fetch_taken(fetch_taken),
    .interlocked(interlocked), .port(lnk));
  cpiv_cop_end #(.CP_ID(1)) i_cpiv_cop_end (.clk(clk), .sys_rst(sys_rst),
    .exec_busy(exec_busy), .exec_done(exec_done), .acc_valid(acc_valid),
    .acc_instr(acc_instr), .acc_cancel(acc_cancel), .port(lnk));
  cpiv_properties i_cpiv_properties (.clk(clk), .sys_rst(sys_rst),
    .cop_instr_bus(lnk.cop_instr_bus),
    .issue_hint_valid(lnk.issue_hint_valid),
    .decode_confirm_valid(lnk.decode_confirm_valid),
    .decode_stage_stall(lnk.decode_stage_stall),
    .execute_stage_stall(lnk.execute_stage_stall),
    .pipeline_flush(lnk.pipeline_flush),
    .coproc_busy_oe(lnk.coproc_busy_oe),
    .coproc_busy_execute(lnk.coproc_busy_execute));

  always #10 clk = ~clk;

  task automatic close_out();
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk_bit(logic got, logic exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_word(cpiv_instr_t got, cpiv_instr_t exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic offer(cpiv_instr_t i, logic c, logic a);
    fetch_valid = 1;
    fetch_instr = i;
    fetch_cop = c;
    fetch_abort = a;
    step();
    fetch_valid = 0;
  endtask
  task automatic wait_acc();
    int n;
    n = 0;
    while (acc_valid !== 1'b1 && n < 10) begin
      step();
      n++;
    end
    chk_bit(acc_valid, 1'b1);
    if (n == 10) close_out();
  endtask
  task automatic kill(logic f, logic b);
    offer(26'h0000166, 1, 0);
    flush_req = f;
    branch_kill = b;
    step();
    flush_req = 0;
    branch_kill = 0;
    chk_bit(lnk.decode_confirm_valid, 1'b0);
    chk_bit(lnk.pipeline_flush, f);
    step();
    chk_bit(acc_valid, 1'b0);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    #1 sys_rst = 0;
    chk_bit(lnk.issue_hint_valid, 1'b0);
    chk_bit(lnk.decode_confirm_valid, 1'b0);
    foreach (rows[k]) begin
      offer(rows[k].instr, rows[k].cop, rows[k].abort);
      chk_bit(fetch_taken, 1'b1);
      chk_bit(lnk.issue_hint_valid, rows[k].hint);
      chk_word(lnk.cop_instr_bus, rows[k].hint ? rows[k].instr : '0);
      step();
      chk_bit(lnk.decode_confirm_valid, rows[k].conf);
      step();
      chk_bit(acc_valid, rows[k].acc);
      if (rows[k].acc) chk_word(acc_instr, rows[k].instr);
      exec_done = 1;
      step();
      exec_done = 0;
    end
    hold_decode = 1;
    hold_execute = 1;
    offer(26'h0000145, 1, 0);
    repeat (3) begin
      step();
      chk_bit(interlocked, 1'b1);
      chk_bit(acc_valid, 1'b0);
    end
    hold_decode = 0;
    hold_execute = 0;
    wait_acc();
    chk_word(acc_instr, 26'h0000145);
    exec_done = 1;
    step();
    exec_done = 0;
    kill(1, 0);
    kill(0, 1);
    exec_busy = 1;
    offer(26'h0000181, 1, 0);
    wait_acc();
    chk_bit(lnk.coproc_busy_execute, 1'b1);
    cancel_req = 1;
    step();
    cancel_req = 0;
    step();
    chk_bit(acc_cancel, 1'b1);
    exec_busy = 0;
    offer(26'h0000199, 1, 0);
    sys_rst = 1;
    step();
    sys_rst = 0;
    chk_bit(lnk.issue_hint_valid, 1'b0);
    close_out();
  end
endmodule
